// ===== hdl/uwsc_pkg.sv
// package of offsets, field layouts, reset values and carriers for the window and serdes control registers
package uwsc_pkg;

    // register byte offsets
    localparam logic [7:0] UPPER_SETUP_OFFSET = 8'h38;
    localparam logic [7:0] UPPER_BASE_OFFSET = 8'h64;
    localparam logic [7:0] PHY_CTRL_OFFSET = 8'h68;

    // setup register layout
    localparam int SETUP_ENABLE_BIT = 31;
    localparam logic [31:0] UPPER_SETUP_RESET = 32'h0000_0000;

    // upper base reset
    localparam logic [31:0] UPPER_BASE_RESET = 32'h0000_0000;

    // control register field positions
    localparam int DRV_CUR_LSB = 0;
    localparam int DRV_CUR_MSB = 1;
    localparam int CUR_SCALE_LSB = 2;
    localparam int CUR_SCALE_MSB = 5;
    localparam int DEEMPH_LSB = 8;
    localparam int DEEMPH_MSB = 11;
    localparam int TX_TERM_LSB = 12;
    localparam int TX_TERM_MSB = 13;
    localparam int RX_TERM_LSB = 14;
    localparam int RX_TERM_MSB = 15;
    localparam int ADDR64_EN_BIT = 21;

    // control register field reset values
    localparam logic [1:0] DRV_CUR_RESET = 2'h0;
    localparam logic [3:0] CUR_SCALE_RESET = 4'h0;
    localparam logic [3:0] DEEMPH_RESET = 4'h8;
    localparam logic [1:0] TX_TERM_RESET = 2'h0;
    localparam logic [1:0] RX_TERM_RESET = 2'h0;
    localparam logic ADDR64_EN_RESET = 1'b0;

    // driver current code that must never be stored
    localparam logic [1:0] DRV_CUR_RESERVED = 2'h3;

    // transmitter and receiver control fields as driven to the link electricals
    typedef struct packed {
        logic [1:0] drv_cur;
        logic [3:0] cur_scale;
        logic [3:0] deemph;
        logic [1:0] tx_term;
        logic [1:0] rx_term;
        logic addr64_en;
    } uwsc_phy_ctrl_type;

    // transaction seen on the secondary parallel bus
    typedef struct packed {
        logic valid;
        logic is64;
        logic [63:0] addr;
        logic ds3_hit;
        logic lower_hit;
    } uwsc_txn_type;

    // decode result for the secondary bus transaction
    typedef struct packed {
        logic valid;
        logic fwd_up;
        logic win_hit;
        logic xlate;
    } uwsc_dec_type;

endpackage

// ===== hdl/uwsc_window_decode.sv
// registered decode of secondary bus transactions against the upper window
`timescale 1ns/1ps
module uwsc_window_decode (
    input wire logic pclk,
    input wire logic presetn,
    input wire uwsc_pkg::uwsc_txn_type txn,
    input wire logic [31:0] upper_base,
    input wire logic [31:0] upper_mask,
    input wire logic win_en,
    input wire logic addr64_en,
    output uwsc_pkg::uwsc_dec_type dec
);

    ////////////////////////////////////////////////////////////////////////
    // combinational match

    logic upper_match;
    logic hit64;

    // only bits that the setup register makes part of the window are compared
    assign upper_match = ((txn.addr[63:32] & upper_mask) == (upper_base & upper_mask));
    // a disabled window or 32-bit mode takes the upper half out of decode
    assign hit64 = win_en && addr64_en && txn.is64 && txn.lower_hit && upper_match;

    ////////////////////////////////////////////////////////////////////////
    // registered result

    // one cycle after the transaction is offered the result stands for one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec <= '0;
        end else begin
            dec.valid <= txn.valid;
            dec.win_hit <= txn.valid && hit64;
            dec.xlate <= txn.valid && hit64;
            dec.fwd_up <= txn.valid && txn.is64 && !txn.ds3_hit;
        end
    end

endmodule // uwsc_window_decode

// ===== hdl/uwsc_regs.sv
// apb register bank holding the upper window base, its setup and the serdes control fields
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module uwsc_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic setup_load,
    input wire logic [31:0] setup_load_data,
    input wire uwsc_pkg::uwsc_txn_type txn,
    output uwsc_pkg::uwsc_phy_ctrl_type phy_ctrl,
    output uwsc_pkg::uwsc_dec_type dec,
    output logic window_enabled
);

    ////////////////////////////////////////////////////////////////////////
    // storage

    logic [31:0] upper_setup_reg;
    logic [31:0] upper_base_reg;
    logic [31:0] upper_base_next;
    logic [31:0] upper_mask;
    logic [31:0] lane_mask;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_next_word;
    logic [31:0] read_word;
    logic win_en;
    logic addr_hit;

    ////////////////////////////////////////////////////////////////////////
    // bus handshake

    logic access;
    logic commit;
    logic wr_commit;

    // access phase seen; answer comes one edge later so prdata is registered
    assign access = psel && penable;
    // the edge at which the master samples pready high
    assign commit = access && pready;
    assign wr_commit = commit && pwrite;

    // pready rises one edge into the access phase and falls after the commit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access && !pready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode

    // only the three mapped words answer without error
    always_comb begin
        addr_hit = 1'b0;
        unique case (paddr)
            uwsc_pkg::UPPER_SETUP_OFFSET: addr_hit = 1'b1;
            uwsc_pkg::UPPER_BASE_OFFSET: addr_hit = 1'b1;
            uwsc_pkg::PHY_CTRL_OFFSET: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // error flag launched with pready so both stand for the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access && !pready && !addr_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte lanes

    // each strobe bit opens its byte of the write data
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign lane_mask[lane*8 +: 8] = {8{pstrb[lane]}};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // upper window setup

    // a local loader wins over a bus write landing in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_setup_reg <= uwsc_pkg::UPPER_SETUP_RESET;
        end else if (setup_load) begin
            upper_setup_reg <= setup_load_data;
        end else if (wr_commit && paddr == uwsc_pkg::UPPER_SETUP_OFFSET) begin
            upper_setup_reg <= (pwdata & lane_mask) | (upper_setup_reg & ~lane_mask);
        end
    end

    // the enable bit switches the whole upper base off
    assign win_en = upper_setup_reg[uwsc_pkg::SETUP_ENABLE_BIT];
    // remaining setup bits name the upper base bits that belong to the window
    assign upper_mask = win_en ? {1'b1, upper_setup_reg[30:0]} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // upper window base

    // only bits opened by both the setup mask and a byte strobe take the write
    assign upper_base_next = (pwdata & upper_mask & lane_mask) | (upper_base_reg & ~(upper_mask & lane_mask));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_base_reg <= uwsc_pkg::UPPER_BASE_RESET;
        end else if (wr_commit && paddr == uwsc_pkg::UPPER_BASE_OFFSET) begin
            upper_base_reg <= upper_base_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter and receiver control

    // present the stored fields as one word for byte-lane merging
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[uwsc_pkg::DRV_CUR_MSB:uwsc_pkg::DRV_CUR_LSB] = phy_ctrl.drv_cur;
        ctrl_word[uwsc_pkg::CUR_SCALE_MSB:uwsc_pkg::CUR_SCALE_LSB] = phy_ctrl.cur_scale;
        ctrl_word[uwsc_pkg::DEEMPH_MSB:uwsc_pkg::DEEMPH_LSB] = phy_ctrl.deemph;
        ctrl_word[uwsc_pkg::TX_TERM_MSB:uwsc_pkg::TX_TERM_LSB] = phy_ctrl.tx_term;
        ctrl_word[uwsc_pkg::RX_TERM_MSB:uwsc_pkg::RX_TERM_LSB] = phy_ctrl.rx_term;
        ctrl_word[uwsc_pkg::ADDR64_EN_BIT] = phy_ctrl.addr64_en;
    end

    assign ctrl_next_word = (pwdata & lane_mask) | (ctrl_word & ~lane_mask);

    // fields drive the link electricals straight from these flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_ctrl.drv_cur <= uwsc_pkg::DRV_CUR_RESET;
            phy_ctrl.cur_scale <= uwsc_pkg::CUR_SCALE_RESET;
            phy_ctrl.deemph <= uwsc_pkg::DEEMPH_RESET;
            phy_ctrl.tx_term <= uwsc_pkg::TX_TERM_RESET;
            phy_ctrl.rx_term <= uwsc_pkg::RX_TERM_RESET;
            phy_ctrl.addr64_en <= uwsc_pkg::ADDR64_EN_RESET;
        end else if (wr_commit && paddr == uwsc_pkg::PHY_CTRL_OFFSET) begin
            // the reserved current code is refused; the old code stays
            if (ctrl_next_word[uwsc_pkg::DRV_CUR_MSB:uwsc_pkg::DRV_CUR_LSB] != uwsc_pkg::DRV_CUR_RESERVED) begin
                phy_ctrl.drv_cur <= ctrl_next_word[uwsc_pkg::DRV_CUR_MSB:uwsc_pkg::DRV_CUR_LSB];
            end
            phy_ctrl.cur_scale <= ctrl_next_word[uwsc_pkg::CUR_SCALE_MSB:uwsc_pkg::CUR_SCALE_LSB];
            phy_ctrl.deemph <= ctrl_next_word[uwsc_pkg::DEEMPH_MSB:uwsc_pkg::DEEMPH_LSB];
            phy_ctrl.tx_term <= ctrl_next_word[uwsc_pkg::TX_TERM_MSB:uwsc_pkg::TX_TERM_LSB];
            phy_ctrl.rx_term <= ctrl_next_word[uwsc_pkg::RX_TERM_MSB:uwsc_pkg::RX_TERM_LSB];
            phy_ctrl.addr64_en <= ctrl_next_word[uwsc_pkg::ADDR64_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data

    // upper base reads back only its window bits; unmapped words read zero
    always_comb begin
        read_word = 32'h0000_0000;
        unique case (paddr)
            uwsc_pkg::UPPER_SETUP_OFFSET: read_word = upper_setup_reg;
            uwsc_pkg::UPPER_BASE_OFFSET: read_word = upper_base_reg & upper_mask;
            uwsc_pkg::PHY_CTRL_OFFSET: read_word = ctrl_word;
            default: read_word = 32'h0000_0000;
        endcase
    end

    // read data is captured as pready rises and cleared otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (access && !pready && !pwrite) begin
            prdata <= read_word;
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // window status

    // software and the core see whether the upper base is active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window_enabled <= 1'b0;
        end else begin
            window_enabled <= win_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // secondary bus decode

    uwsc_window_decode u_decode (
        .pclk(pclk),
        .presetn(presetn),
        .txn(txn),
        .upper_base(upper_base_reg),
        .upper_mask(upper_mask),
        .win_en(win_en),
        .addr64_en(phy_ctrl.addr64_en),
        .dec(dec)
    );

endmodule // uwsc_regs

// ===== verification/uwsc_regs_assertions.sv
// checker of apb timing, field limits and window decode relations for the register bank
`timescale 1ns/1ps
module uwsc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic setup_load,
    input wire logic [31:0] setup_load_data,
    input wire uwsc_pkg::uwsc_txn_type txn,
    input wire uwsc_pkg::uwsc_phy_ctrl_type phy_ctrl,
    input wire uwsc_pkg::uwsc_dec_type dec,
    input wire logic window_enabled
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // bus timing and error answer
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("access not ended after one wait");
    property p_err; pready || pslverr |-> pready && pslverr == !(paddr inside {8'h38, 8'h64, 8'h68}); endproperty
    a_err: assert property (p_err) else $error("error answer wrong");
    ////////////////////////////////////////////////////////////////
    // control fields
    property p_rst; $rose(presetn) |-> phy_ctrl.deemph == 4'h8 && phy_ctrl.drv_cur == 2'h0 && phy_ctrl.cur_scale == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("control reset values wrong");
    property p_drv; pready && pwrite && paddr == 8'h68 && pstrb[0] && pwdata[1:0] == 2'h3 |=> $stable(phy_ctrl.drv_cur); endproperty
    a_drv: assert property (p_drv) else $error("reserved current code stored");
    property p_wr; pready && pwrite && paddr == 8'h68 && pstrb[1] |=> phy_ctrl.deemph == $past(pwdata[11:8]) && phy_ctrl.rx_term == $past(pwdata[15:14]); endproperty
    a_wr: assert property (p_wr) else $error("control write lost");
    ////////////////////////////////////////////////////////////////
    // window enable and decode
    property p_win; setup_load |-> ##2 window_enabled == $past(setup_load_data[31], 2); endproperty
    a_win: assert property (p_win) else $error("enable does not follow setup");
    property p_fwd; dec.fwd_up == $past(txn.valid && txn.is64 && !txn.ds3_hit); endproperty
    a_fwd: assert property (p_fwd) else $error("upstream forward wrong");
    property p_a64; dec.win_hit |-> $past(phy_ctrl.addr64_en && txn.valid && txn.is64 && txn.lower_hit); endproperty
    a_a64: assert property (p_a64) else $error("hit without 64-bit decode");
    property p_xl; !$past(phy_ctrl.addr64_en) |-> !dec.xlate; endproperty
    a_xl: assert property (p_xl) else $error("translation outside hit");
endmodule // uwsc_checker

// ===== verification/tb_uwsc_regs.sv
// self-checking bench for the window and serdes control register bank
`timescale 1ns/1ps
module tb_uwsc_regs;
    logic pclk, presetn, psel, penable, pwrite, setup_load, pready, pslverr, window_enabled, w;
    logic [7:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, setup_load_data, ctrl, setup, base, m;
    logic [95:0] r;
    logic [32:0] q[$];
    uwsc_pkg::uwsc_txn_type txn, t;
    uwsc_pkg::uwsc_phy_ctrl_type phy_ctrl;
    uwsc_pkg::uwsc_dec_type dec;
    int fails, checked, seed, i, c, n;
    uwsc_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .setup_load(setup_load), .setup_load_data(setup_load_data), .txn(txn), .phy_ctrl(phy_ctrl),
        .dec(dec), .window_enabled(window_enabled));
    ////////////////////////////////////////////////////////////////
    // clock
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one apb transfer, expected answer noted for the monitor
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [32:0] e);
        q.push_back(e);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            fails++;
            wrap_up;
        end
        @(posedge pclk);
    endtask
    task wctrl(input logic [31:0] d, input logic [3:0] s);
        logic [31:0] bm, nx;
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        nx = ((ctrl & ~bm) | (d & bm)) & 32'h0020_FF3F;
        if (nx[1:0] == 2'h3)
            nx[1:0] = ctrl[1:0];
        ctrl = nx;
        apb(1'h1, 8'h68, d, s, 33'h0);
        chk({18'h0, phy_ctrl}, {18'h0, ctrl[1:0], ctrl[5:2], ctrl[11:8], ctrl[13:12], ctrl[15:14], ctrl[21]});
    endtask
    task wbase(input logic [31:0] d);
        base = (base & ~m) | (d & m);
        apb(1'h1, 8'h64, d, 4'hF, 33'h0);
        apb(1'h0, 8'h64, 32'h0, 4'hF, {1'h0, base & m});
    endtask
    task load(input logic [31:0] d);
        setup_load <= 1'h1;
        setup_load_data <= d;
        @(posedge pclk);
        setup_load <= 1'h0;
        setup = d;
        m = d[31] ? {1'h1, d[30:0]} : 32'h0;
        repeat (2) @(posedge pclk);
        chk({32'h0, window_enabled}, {32'h0, d[31]});
        apb(1'h0, 8'h64, 32'h0, 4'hF, {1'h0, base & m});
    endtask
    ////////////////////////////////////////////////////////////////
    // monitor: each answer against the oldest note
    always @(posedge pclk) begin
        if (pready === 1'h1) begin
            if (q.size() == 0) begin
                fails++;
                $display("MISMATCH %0t unexpected answer", $time);
            end else begin
                chk({pslverr, prdata}, q.pop_front());
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {psel, penable, pwrite, setup_load, presetn} = 5'h0;
        {paddr, pstrb, pwdata, setup_load_data, setup, base, m} = 172'h0;
        txn = '0;
        ctrl = 32'h0000_0800;
        seed = 9;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, 8'h68, 32'h0, 4'hF, {1'h0, ctrl});
        apb(1'h0, 8'h64, 32'h0, 4'hF, 33'h0);
        $display("test reset done");
        for (i = 0; i < 4; i++)
            wctrl({16'h0, i[1:0], i[1:0], 10'h0, i[1:0]}, 4'h3);
        for (i = 0; i < 40; i++) begin
            wctrl($random(seed), 4'($random(seed)));
            apb(1'h0, 8'h68, 32'h0, 4'hF, {1'h0, ctrl});
        end
        apb(1'h1, 8'h6C, 32'hFFFF_FFFF, 4'hF, {1'h1, 32'h0});
        apb(1'h0, 8'h00, 32'h0, 4'hF, {1'h1, 32'h0});
        apb(1'h0, 8'h68, 32'h0, 4'hF, {1'h0, ctrl});
        $display("test control done");
        load(32'h8000_FFFF);
        wbase(32'hFFFF_FFFF);
        load(32'h0);
        wbase(32'h1234_5678);
        load(32'hFFFF_FFFF);
        // bus write to the setup word, only the low byte opened
        apb(1'h1, 8'h38, 32'h1234_5600, 4'h1, 33'h0);
        setup = 32'hFFFF_FF00;
        m = setup;
        apb(1'h0, 8'h38, 32'h0, 4'hF, {1'h0, setup});
        apb(1'h0, 8'h64, 32'h0, 4'hF, {1'h0, base & m});
        $display("test window done");
        for (c = 0; c < 3; c++) begin
            load(c == 2 ? 32'h0000_FF00 : 32'h8000_FF00);
            wctrl(c == 1 ? 32'h0 : 32'h0020_0000, 4'h4);
            for (i = 0; i < 48; i++) begin
                r = {$random(seed), $random(seed), $random(seed)};
                t = r[67:0];
                t.lower_hit = t.lower_hit | r[94];
                if (r[95])
                    t.addr[63:32] = base;
                else
                    t.addr[40] = ~base[8];
                txn <= t;
                @(posedge pclk);
                txn <= '0;
                @(posedge pclk);
                w = t.valid & t.is64 & t.lower_hit & setup[31] & ctrl[21] & (((t.addr[63:32] ^ base) & m) == 32'h0);
                chk({29'h0, dec}, {29'h0, t.valid, t.valid & t.is64 & ~t.ds3_hit, w, w});
            end
        end
        $display("test decode done");
        wrap_up;
    end
endmodule // tb_uwsc_regs
bind uwsc_regs uwsc_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .setup_load(setup_load), .setup_load_data(setup_load_data), .txn(txn), .phy_ctrl(phy_ctrl), .dec(dec),
    .window_enabled(window_enabled));
